/* File: hw/ea_adder.sv */
// effective address adder: base-or-zero plus a selected offset
// assumes operand values come from the core's register read on this cycle
`timescale 1ns/100ps
module ea_adder
(
  input  wire logic [4:0]      base_register_field,
  input  wire logic [31:0]     base_value,
  input  wire logic [31:0]     index_value,
  input  wire logic [15:0]     disp,
  input  wire lsu_pkg::offsel_t sel,
  output logic [31:0]          effective_address
);
  logic [31:0] base_term;
  logic [31:0] ofs_term;

  // base field zero means the value zero, not register zero
  always_comb
  begin
    base_term = (base_register_field == 5'h00) ? 32'h0 : base_value;
    case (sel)
      lsu_pkg::OFS_DISP:  ofs_term = {{16{disp[15]}}, disp};
      lsu_pkg::OFS_INDEX: ofs_term = index_value;
      default:            ofs_term = 32'h0;
    endcase
    effective_address = base_term + ofs_term;
  end
endmodule

/* File: hw/lsu_consts.svh */
// constants for the multiple, string and fp address-generation unit
// assumes the including file sees lsu_pkg
// Operation
// - multiple: address is base-or-zero plus displacement; moves 32 minus first-register words
// - last register's low byte meets quad word end; misaligned runs slower
// - a translation fault on any access, second page included, ends the transfer
// - load-multiple with base in loaded range, or base zero, is invalid
// - optional alignment exception for multiples under little-endian order
// - string immediate uses base-or-zero; string indexed adds index register
// - strings accept any byte alignment; misaligned costs extra cycles
// - optional alignment exception for strings under little-endian order
// - fp access to a direct-store segment raises alignment, no access
// - fp displacement is sign-extended to 32 bits and added to base
// - fp displacement form with base field zero adds zero
// - fp indexed sums two registers; base field zero contributes zero
// - fp update form with base field zero is invalid
// - fp encoding with condition record bit set is invalid
// - store denormalization ignores the underflow enable bit
`ifndef LSU_CONSTS_SVH
`define LSU_CONSTS_SVH
`define MW_REG_COUNT      6'h20
`define STR_NB_ZERO_COUNT 8'h20
`define WORD_BYTES        8'h04
`define ADDR_RESET        32'h0000_0000
`define WORD_RESET        32'h0000_0000
`endif

/* File: hw/lsu_pkg.sv */
// types for the multiple, string and fp address-generation unit
// assumes nothing beyond a SystemVerilog compiler
package lsu_pkg;

  typedef enum logic [2:0] {
    OP_LD_MULTI  = 3'h0,
    OP_ST_MULTI  = 3'h1,
    OP_LD_STR_IM = 3'h2,
    OP_LD_STR_IX = 3'h3,
    OP_ST_STR_IM = 3'h4,
    OP_ST_STR_IX = 3'h5,
    OP_FP_DISP   = 3'h6,
    OP_FP_INDEX  = 3'h7
  } op_t;

  typedef enum logic [1:0] {
    OFS_ZERO  = 2'h0,
    OFS_DISP  = 2'h1,
    OFS_INDEX = 2'h2
  } offsel_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'h0,
    ST_FETCH  = 2'h1,
    ST_ACCESS = 2'h2
  } state_t;

  typedef struct packed {
    state_t      st;
    logic [31:0] addr;
    logic [4:0]  reg_idx;
    logic [1:0]  bpos;
    logic [7:0]  remain;
    logic [31:0] word;
    logic        load;
    logic        req;
    logic        we;
    logic        wsize;
    logic [31:0] maddr;
    logic [31:0] wdata;
    logic        gwr;
    logic [4:0]  gidx;
    logic [31:0] gdata;
    logic [4:0]  rd_idx;
    logic        done;
    logic        e_align;
    logic        e_inv;
    logic        e_dsi;
    logic [31:0] ea;
    logic        ea_vld;
    logic        denorm;
  } core_t;

endpackage

/* File: hw/multi_string_fp_ls_agen.sv */
// load/store multiple, string transfer and fp address generation
// assumes same-clock core: gpr_rd_data follows gpr_rd_idx combinationally,
// memory holds mem_ready high one cycle per accepted access
`timescale 1ns/100ps
`include "lsu_consts.svh"
module multi_string_fp_ls_agen
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        cmd_valid,
  input  wire lsu_pkg::op_t cmd_op,
  input  wire logic [4:0]  cmd_first_reg,
  input  wire logic [4:0]  base_register_field,
  input  wire logic [15:0] cmd_disp,
  input  wire logic [4:0]  byte_count_field,
  input  wire logic [6:0]  xer_byte_count,
  input  wire logic [31:0] base_value,
  input  wire logic [31:0] index_value,
  input  wire logic        fp_update,
  input  wire logic        condition_record_bit,
  input  wire logic        little_endian,
  input  wire logic        le_align_trap,
  input  wire logic        direct_store_seg,
  input  wire logic        fp_denorm_needed,
  input  wire logic [31:0] gpr_rd_data,
  input  wire logic        mem_ready,
  input  wire logic        mem_dsi,
  input  wire logic [31:0] mem_rdata,
  output logic             cmd_busy,
  output logic             cmd_done,
  output logic             mem_req,
  output logic             mem_we,
  output logic             mem_word,
  output logic [31:0]      mem_addr,
  output logic [31:0]      mem_wdata,
  output logic [4:0]       gpr_rd_idx,
  output logic             gpr_wr_en,
  output logic [4:0]       gpr_wr_idx,
  output logic [31:0]      gpr_wr_data,
  output logic             exc_alignment,
  output logic             exc_invalid_form,
  output logic             exc_dsi,
  output logic [31:0]      fp_ea,
  output logic             fp_ea_valid,
  output logic             fp_store_denorm
);
  lsu_pkg::core_t   s_r;
  lsu_pkg::core_t   s_nxt;
  lsu_pkg::offsel_t sel;
  logic [31:0]      ea;
  logic             take;
  logic             is_multi;
  logic             is_fp;
  logic             lmw_bad;
  logic [7:0]       count;
  logic [7:0]       step;
  logic [7:0]       left;
  logic             reg_end;

  ea_adder u_ea
  (
    .base_register_field (base_register_field),
    .base_value          (base_value),
    .index_value         (index_value),
    .disp                (cmd_disp),
    .sel                 (sel),
    .effective_address   (ea)
  );

  // decode of the command and its byte count
  always_comb
  begin
    take     = cmd_valid && (s_r.st == lsu_pkg::ST_IDLE);
    is_multi = (cmd_op == lsu_pkg::OP_LD_MULTI) ||
               (cmd_op == lsu_pkg::OP_ST_MULTI);
    is_fp    = (cmd_op == lsu_pkg::OP_FP_DISP) ||
               (cmd_op == lsu_pkg::OP_FP_INDEX);
    lmw_bad  = (cmd_op == lsu_pkg::OP_LD_MULTI) &&
               ((base_register_field >= cmd_first_reg) ||
                (base_register_field == 5'h00));
    case (cmd_op)
      lsu_pkg::OP_LD_MULTI,
      lsu_pkg::OP_ST_MULTI,
      lsu_pkg::OP_FP_DISP:   sel = lsu_pkg::OFS_DISP;
      lsu_pkg::OP_LD_STR_IX,
      lsu_pkg::OP_ST_STR_IX,
      lsu_pkg::OP_FP_INDEX:  sel = lsu_pkg::OFS_INDEX;
      default:               sel = lsu_pkg::OFS_ZERO;
    endcase
    case (cmd_op)
      lsu_pkg::OP_LD_MULTI,
      lsu_pkg::OP_ST_MULTI:
        count = {(`MW_REG_COUNT - {1'b0, cmd_first_reg}), 2'b00};
      lsu_pkg::OP_LD_STR_IM,
      lsu_pkg::OP_ST_STR_IM:
        count = (byte_count_field == 5'h00) ? `STR_NB_ZERO_COUNT
                                            : {3'h0, byte_count_field};
      default:
        count = {1'h0, xer_byte_count};
    endcase
  end

  // next state: one engine moves words at an aligned register start with at least four bytes left, bytes otherwise
  always_comb
  begin
    s_nxt         = s_r;
    s_nxt.done    = 1'b0;
    s_nxt.gwr     = 1'b0;
    s_nxt.e_align = 1'b0;
    s_nxt.e_inv   = 1'b0;
    s_nxt.e_dsi   = 1'b0;
    s_nxt.ea_vld  = 1'b0;
    step          = s_r.wsize ? `WORD_BYTES : 8'h01;
    left          = s_r.remain - step;
    reg_end       = s_r.wsize || (s_r.bpos == 2'h3) || (left == 8'h00);
    case (s_r.st)
      lsu_pkg::ST_IDLE:
      begin
        if (take && is_fp)
        begin
          s_nxt.done = 1'b1;
          s_nxt.ea   = ea;
          if (condition_record_bit || (fp_update &&
              (base_register_field == 5'h00)))
            s_nxt.e_inv = 1'b1;
          else if (direct_store_seg)
            s_nxt.e_align = 1'b1;
          else
          begin
            s_nxt.ea_vld = 1'b1;
            // denormalization never looks at the underflow enable bit
            s_nxt.denorm = fp_denorm_needed;
          end
        end
        else if (take && little_endian && le_align_trap)
        begin
          s_nxt.done    = 1'b1;
          s_nxt.e_align = 1'b1;
        end
        else if (take && lmw_bad)
        begin
          s_nxt.done  = 1'b1;
          s_nxt.e_inv = 1'b1;
        end
        else if (take)
        begin
          s_nxt.addr    = ea;
          s_nxt.reg_idx = cmd_first_reg;
          s_nxt.rd_idx  = cmd_first_reg;
          s_nxt.bpos    = 2'h0;
          s_nxt.remain  = count;
          s_nxt.word    = `WORD_RESET;
          s_nxt.load    = (cmd_op == lsu_pkg::OP_LD_MULTI) ||
                          (cmd_op == lsu_pkg::OP_LD_STR_IM) ||
                          (cmd_op == lsu_pkg::OP_LD_STR_IX);
          if (count == 8'h00)
            s_nxt.done = 1'b1;
          else
            s_nxt.st = s_nxt.load ? lsu_pkg::ST_ACCESS : lsu_pkg::ST_FETCH;
        end
      end
      lsu_pkg::ST_FETCH:
      begin
        s_nxt.word = gpr_rd_data;
        s_nxt.st   = lsu_pkg::ST_ACCESS;
      end
      lsu_pkg::ST_ACCESS:
      begin
        if (!s_r.req)
        begin
          // word access only when aligned; else byte by byte, any alignment
          s_nxt.wsize = (s_r.addr[1:0] == 2'h0) && (s_r.bpos == 2'h0) &&
                        (s_r.remain >= `WORD_BYTES);
          s_nxt.req   = 1'b1;
          s_nxt.we    = !s_r.load;
          s_nxt.maddr = s_r.addr;
          s_nxt.wdata = s_nxt.wsize ? s_r.word
                        : {24'h0, s_r.word[31 - {s_r.bpos, 3'h0} -: 8]};
        end
        else if (mem_ready)
        begin
          s_nxt.req = 1'b0;
          if (mem_dsi)
          begin
            // the fault aborts mid-transfer; the handler restarts it
            s_nxt.e_dsi = 1'b1;
            s_nxt.done  = 1'b1;
            s_nxt.st    = lsu_pkg::ST_IDLE;
          end
          else
          begin
            s_nxt.addr   = s_r.addr + {24'h0, step};
            s_nxt.remain = left;
            s_nxt.bpos   = s_r.wsize ? 2'h0 : s_r.bpos + 2'h1;
            if (s_r.load && !s_r.wsize)
              s_nxt.word[31 - {s_r.bpos, 3'h0} -: 8] = mem_rdata[7:0];
            if (reg_end)
            begin
              s_nxt.bpos    = 2'h0;
              s_nxt.reg_idx = s_r.reg_idx + 5'h01;
              s_nxt.rd_idx  = s_r.reg_idx + 5'h01;
              if (s_r.load)
              begin
                // unfilled low bytes stay zero from the cleared word
                s_nxt.gwr   = 1'b1;
                s_nxt.gidx  = s_r.reg_idx;
                s_nxt.gdata = s_r.wsize ? mem_rdata : s_nxt.word;
                s_nxt.word  = `WORD_RESET;
              end
              else if (left != 8'h00)
                s_nxt.st = lsu_pkg::ST_FETCH;
            end
            if (left == 8'h00)
            begin
              s_nxt.done = 1'b1;
              s_nxt.st   = lsu_pkg::ST_IDLE;
            end
          end
        end
      end
      default:
        s_nxt.st = lsu_pkg::ST_IDLE;
    endcase
  end

  // all state in one register
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      s_r       <= '0;
      s_r.st    <= lsu_pkg::ST_IDLE;
      s_r.addr  <= `ADDR_RESET;
    end
    else
      s_r <= s_nxt;
  end

  // outputs straight from the state flops
  assign cmd_busy         = (s_r.st != lsu_pkg::ST_IDLE);
  assign cmd_done         = s_r.done;
  assign mem_req          = s_r.req;
  assign mem_we           = s_r.we;
  assign mem_word         = s_r.wsize;
  assign mem_addr         = s_r.maddr;
  assign mem_wdata        = s_r.wdata;
  assign gpr_rd_idx       = s_r.rd_idx;
  assign gpr_wr_en        = s_r.gwr;
  assign gpr_wr_idx       = s_r.gidx;
  assign gpr_wr_data      = s_r.gdata;
  assign exc_alignment    = s_r.e_align;
  assign exc_invalid_form = s_r.e_inv;
  assign exc_dsi          = s_r.e_dsi;
  assign fp_ea            = s_r.ea;
  assign fp_ea_valid      = s_r.ea_vld;
  assign fp_store_denorm  = s_r.denorm;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_fp_take;
    take && is_fp;
  endsequence

  sequence s_fp_clean;
    s_fp_take ##0 !condition_record_bit && !(fp_update &&
      base_register_field == 5'h00);
  endsequence

  lmw_invalid_a: assert property (take && lmw_bad &&
    !(little_endian && le_align_trap) |=> exc_invalid_form && cmd_done &&
    !cmd_busy)
    else $error("bad load-multiple form not flagged");

  fp_record_a: assert property (s_fp_take ##0 condition_record_bit
    |=> exc_invalid_form && !fp_ea_valid)
    else $error("fp record bit not flagged invalid");

  fp_update_a: assert property (s_fp_take ##0 fp_update &&
    base_register_field == 5'h00 |=> exc_invalid_form)
    else $error("fp update with base zero not flagged");

  fp_direct_a: assert property (s_fp_clean ##0 direct_store_seg
    |=> exc_alignment && !fp_ea_valid)
    else $error("direct-store fp access not refused");

  fp_disp_ea_a: assert property (s_fp_clean ##0 !direct_store_seg &&
    cmd_op == lsu_pkg::OP_FP_DISP |=> fp_ea_valid && fp_ea ==
    (($past(base_register_field) == 5'h00 ? 32'h0 : $past(base_value)) +
    {{16{$past(cmd_disp[15])}}, $past(cmd_disp)}))
    else $error("fp displacement address wrong");

  fp_index_ea_a: assert property (s_fp_clean ##0 !direct_store_seg &&
    cmd_op == lsu_pkg::OP_FP_INDEX |=> fp_ea ==
    (($past(base_register_field) == 5'h00 ? 32'h0 : $past(base_value)) +
    $past(index_value)))
    else $error("fp indexed address wrong");

  le_trap_a: assert property (take && !is_fp && little_endian &&
    le_align_trap |=> exc_alignment ##1 !mem_req)
    else $error("little-endian trap not taken");

  dsi_abort_a: assert property (mem_req && mem_ready && mem_dsi
    |=> exc_dsi && cmd_done && !cmd_busy ##1 !mem_req)
    else $error("translation fault did not end transfer");

  word_align_a: assert property (mem_req && mem_word
    |-> mem_addr[1:0] == 2'h0)
    else $error("word access on misaligned address");

  denorm_a: assert property (s_fp_clean ##0 !direct_store_seg
    |=> fp_store_denorm == $past(fp_denorm_needed))
    else $error("denormalization gated wrongly");
endmodule

/* File: verification/mem_responder.sv */
// memory and translation partner for the load/store address unit
// assumes one outstanding access and a same-clock requester
`timescale 1ns/100ps
module mem_responder
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic        mem_word,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  input  wire logic [1:0]  lat,
  input  wire logic [31:0] fault_addr,
  output logic             mem_ready,
  output logic             mem_dsi,
  output logic [31:0]      mem_rdata
);
  logic [7:0]  mem [4096];
  logic [1:0]  wait_r;
  logic [11:0] a;

  // 4 KB image aliased on the low address bits; known byte pattern
  assign a = mem_addr[11:0];
  initial
  begin
    for (int i = 0; i < 4096; i++)
      mem[i] = 8'(i[7:0] ^ {i[11:8], i[3:0]} ^ 8'h3c);
  end

  // answer after a random wait; idle data toggles so stale reads show
  always @(posedge clk_sys)
  begin
    mem_ready <= 1'b0;
    mem_dsi   <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (rst)
    begin
      wait_r    <= lat;
      mem_rdata <= 32'h0;
    end
    else if (mem_req && !mem_ready)
    begin
      if (wait_r != 2'h0)
        wait_r <= wait_r - 2'h1;
      else
      begin
        wait_r    <= lat;
        mem_ready <= 1'b1;
        mem_dsi   <= (mem_addr >= fault_addr);
        if (mem_addr >= fault_addr)
          mem_rdata <= ~mem_rdata;
        else if (mem_we && mem_word)
          {mem[a], mem[a+12'h1], mem[a+12'h2], mem[a+12'h3]} <= mem_wdata;
        else if (mem_we)
          mem[a] <= mem_wdata[7:0];
        else if (mem_word)
          mem_rdata <= {mem[a], mem[a+12'h1], mem[a+12'h2], mem[a+12'h3]};
        else
          mem_rdata <= {24'h0, mem[a]};
      end
    end
  end
endmodule

/* File: verification/testbench.sv */
// self-checking bench: random multiple, string and fp commands
// assumes a register file modelled here and mem_responder as memory
`timescale 1ns/100ps
module testbench;
  logic        clk_sys, rst, cmd_valid, fp_update, condition_record_bit;
  logic        little_endian, le_align_trap, direct_store_seg;
  logic        fp_denorm_needed, mem_ready, mem_dsi, cmd_busy, cmd_done;
  logic        mem_req, mem_we, mem_word, gpr_wr_en, exc_alignment;
  logic        exc_invalid_form, exc_dsi, fp_ea_valid, fp_store_denorm;
  lsu_pkg::op_t cmd_op;
  logic [4:0]  cmd_first_reg, base_register_field, byte_count_field;
  logic [4:0]  gpr_rd_idx, gpr_wr_idx;
  logic [15:0] cmd_disp;
  logic [6:0]  xer_byte_count;
  logic [31:0] base_value, index_value, gpr_rd_data, mem_rdata, mem_addr;
  logic [31:0] mem_wdata, gpr_wr_data, fp_ea, fault_addr, d_ea;
  logic [31:0] general_register [32];
  logic [1:0]  lat;
  logic [3:0]  d_flags;
  logic        d_dn;
  int          seed, fails, tests_run, cyc;

  multi_string_fp_ls_agen uut (.clk_sys, .rst, .cmd_valid, .cmd_op,
    .cmd_first_reg, .base_register_field, .cmd_disp, .byte_count_field,
    .xer_byte_count, .base_value, .index_value, .fp_update,
    .condition_record_bit, .little_endian, .le_align_trap,
    .direct_store_seg, .fp_denorm_needed, .gpr_rd_data, .mem_ready,
    .mem_dsi, .mem_rdata, .cmd_busy, .cmd_done, .mem_req, .mem_we,
    .mem_word, .mem_addr, .mem_wdata, .gpr_rd_idx, .gpr_wr_en, .gpr_wr_idx,
    .gpr_wr_data, .exc_alignment, .exc_invalid_form, .exc_dsi, .fp_ea,
    .fp_ea_valid, .fp_store_denorm);
  mem_responder mem_m (.clk_sys, .rst, .mem_req, .mem_we, .mem_word,
    .mem_addr, .mem_wdata, .lat, .fault_addr, .mem_ready, .mem_dsi,
    .mem_rdata);

  // clock, register file with combinational read, random memory wait
  always #20 clk_sys = ~clk_sys;
  assign gpr_rd_data = general_register[gpr_rd_idx];
  always @(posedge clk_sys)
  begin
    if (gpr_wr_en)
      general_register[gpr_wr_idx] <= gpr_wr_data;
    lat <= 2'($random(seed));
    cyc++;
    if (cyc == 50000)
    begin
      fails++;
      summarize;
    end
  end

  function automatic logic [7:0] pat(input logic [31:0] a);
    return a[7:0] ^ {a[11:8], a[3:0]} ^ 8'h3c;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask

  // one command; flags caught in the done cycle
  task automatic run(input logic [2:0] op, input logic [4:0] fr, bf, nb,
    input logic [31:0] bv, iv, input logic [15:0] d, input logic [6:0] xc,
    input logic [4:0] f);
    int k;
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_op <= lsu_pkg::op_t'(op);
    cmd_first_reg <= fr;
    base_register_field <= bf;
    byte_count_field <= nb;
    base_value <= bv;
    index_value <= iv;
    cmd_disp <= d;
    xer_byte_count <= xc;
    {fp_update, condition_record_bit, little_endian} <= f[4:2];
    {le_align_trap, direct_store_seg} <= f[1:0];
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    // fp and refused commands finish in the take cycle, so look now
    #1;
    k = 0;
    while (cmd_done !== 1'b1 && k < 2000)
    begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    chk(32'(cmd_done), 32'h1);
    chk(32'(cmd_busy), 32'h0);
    d_flags = {exc_alignment, exc_invalid_form, exc_dsi, fp_ea_valid};
    d_ea = fp_ea;
    d_dn = fp_store_denorm;
    // last register write lands one edge after the done pulse
    @(posedge clk_sys);
    #1;
  endtask

  // fp address generation with random forms
  task automatic fp_case();
    logic [31:0] bv, iv, ea;
    logic [15:0] d;
    logic [4:0]  bf;
    logic [5:0]  f;
    logic        inv, ali;
    bv = $random(seed);
    iv = $random(seed);
    d = 16'($random(seed));
    bf = 5'($random(seed)) & 5'h3;
    f = 6'($random(seed));
    fp_denorm_needed <= f[5];
    run(f[0] ? 3'h7 : 3'h6, 5'h0, bf, 5'h0, bv, iv, d, 7'h0,
      {f[1], f[2] & f[3], 2'h0, f[4]});
    inv = (f[2] & f[3]) | (f[1] & (bf == 5'h0));
    ali = !inv & f[4];
    ea = (bf == 5'h0 ? 32'h0 : bv) + (f[0] ? iv : {{16{d[15]}}, d});
    chk(32'(d_flags), {28'h0, ali, inv, 1'b0, !inv & !ali});
    if (!inv && !ali)
    begin
      chk(d_ea, ea);
      chk(32'(d_dn), 32'(f[5]));
    end
  endtask

  // multiple and string transfers; zc forces count field zero
  task automatic xfer(input logic [2:0] op, input logic zc);
    logic [4:0]  fr, bf, nb, f;
    logic [31:0] bv, iv, ea;
    logic [31:0] e [32];
    logic [15:0] d;
    logic [6:0]  xc;
    logic        ld, inv, ali;
    int          n, i, r;
    fr = 5'($random(seed));
    nb = zc ? 5'h0 : 5'($random(seed));
    xc = zc ? 7'h0 : 7'($unsigned($random(seed)) % 41);
    d = 16'($random(seed)) & 16'h00ff;
    // loads stay below 12'h800 and stores above, so loads see the pattern
    iv = $random(seed) & 32'h1f0;
    ld = (op == 3'h0 || op == 3'h2 || op == 3'h3);
    bf = 5'($random(seed));
    if (!ld && bf == 5'h0)
      bf = 5'h1;
    bv = ($random(seed) & 32'h3ff) | (ld ? 32'h0 : 32'h800);
    f = 5'($random(seed)) & 5'h07;
    ali = f[2] & f[1];
    inv = !ali & (op == 3'h0) & (bf == 5'h0 || bf >= fr);
    ea = (bf == 5'h0) ? 32'h0 : bv;
    ea = ea + (op < 3'h2 ? {{16{d[15]}}, d} :
      (op == 3'h3 || op == 3'h5) ? iv : 32'h0);
    n = op < 3'h2 ? 4 * (32 - fr) : (op == 3'h2 || op == 3'h4) ?
      (nb == 5'h0 ? 32 : int'(nb)) : int'(xc);
    e = general_register;
    run(op, fr, bf, nb, bv, iv, d, xc, f);
    chk(32'(d_flags[3:1]), {29'h0, ali, inv, 1'b0});
    for (i = 0; i < n && !ali && !inv; i++)
    begin
      r = (int'(fr) + i / 4) % 32;
      if (ld && i % 4 == 0)
        e[r] = 32'h0;
      if (ld)
        e[r][31 - 8 * (i % 4) -: 8] = pat(ea + 32'(i));
      else
        chk(32'(mem_m.mem[12'(ea + 32'(i))]),
          32'(general_register[r][31 - 8 * (i % 4) -: 8]));
    end
    for (i = 0; i < 32 && ld; i++)
      chk(general_register[i], e[i]);
  endtask

  task summarize;
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // reset, random fp and transfer mix, then a page fault mid-transfer
  initial
  begin
    logic [31:0] e [32];
    seed = 32'h09293351;
    {clk_sys, cmd_valid, fp_update, condition_record_bit} = 4'h0;
    {little_endian, le_align_trap, direct_store_seg} = 3'h0;
    fp_denorm_needed = 1'b0;
    {cmd_first_reg, base_register_field, byte_count_field} = 15'h0;
    {cmd_disp, xer_byte_count, base_value, index_value} = 87'h0;
    cmd_op = lsu_pkg::OP_LD_MULTI;
    lat = 2'h0;
    fault_addr = 32'hffff_ffff;
    rst = 1'b1;
    for (int i = 0; i < 32; i++)
      general_register[i] = {4{8'(i)}} ^ 32'ha5c3_0f01;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (40) fp_case();
    for (int i = 0; i < 60; i++)
      xfer(3'(i % 6), i < 6);
    fault_addr <= 32'h0000_1000;
    e = general_register;
    run(3'h0, 5'd28, 5'h1, 5'h0, 32'h0000_0ff8, 32'h0, 16'h0, 7'h0, 5'h0);
    chk(32'(d_flags[1]), 32'h1);
    e[28] = {pat(32'hff8), pat(32'hff9), pat(32'hffa), pat(32'hffb)};
    e[29] = {pat(32'hffc), pat(32'hffd), pat(32'hffe), pat(32'hfff)};
    for (int i = 28; i < 32; i++)
      chk(general_register[i], e[i]);
    summarize;
  end
endmodule
